// [trace_count_state_sequencer.sv]
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/100ps
// Function
// [R01] seven-bit count of valid trace lines in count register low bits
// [R02] count wrapping from maximum to zero sets the full flag
// [R03] after wrap, counting continues under end or middle alignment
// [R04] writing one to the arm bit clears the count
// [R05] only power-on reset clears the count; other resets keep it
// [R06] count survives a non-power-on reset during a session
// [R07] reading trace data never changes the count
// [R08] count register readable anytime, writes ignored
// [R09] with full clear: 0 none, 1 half line, 2N gives N lines
// [R10] full and zero count: 64 lines; begin alignment disarms, ends session
// [R11] full and nonzero count: 64 lines, oldest overwritten
// [R12] state-control writes accepted only disarmed and profiling inactive
// [R13] four two-bit next-state fields, channel n at bits 2n+1..2n
// [R14] channel 3 follows external event when event select is 10
// [R15] in State1: 01 State2, 10 State3, 11 Final, 00 nothing
// [R16] in State2: 01 State1, 10 State3, 11 Final, 00 nothing
// [R17] simultaneous matches: highest-numbered channel wins
// [R18] only enabled comparators produce matches
// [R19] in State3: 01 State1, 10 State2, 11 Final, 00 nothing
// [R20] full flag cleared by arm write and power-on reset only
// [R21] arming enters State1; Final holds until armed again (the code also leaves Final for disarmed on a disarm write)

`include "trace_seq_cfg.svh"

module trace_count_state_sequencer
    import trace_seq_pkg::*;
(
    // clock and resets
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        por_n,
    // avalon-mm slave
    input  wire logic [11:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // trace and comparator side
    input  wire logic        trace_word_stored,
    input  wire logic [3:0]  comparator_match,
    input  wire logic [3:0]  comparator_enable,
    input  wire logic        external_event,
    input  wire logic        profiling_active_flag,
    // session status
    output logic             session_armed,
    output logic [2:0]       sequencer_state,
    output logic             trace_buffer_full_flag
);

    logic       rst_meta_q;
    logic       rst_sync_q;
    logic       por_meta_q;
    logic       por_sync_q;
    ctl_regs_t  ctl_q;
    ctl_regs_t  ctl_d;
    keep_regs_t keep_q;
    keep_regs_t keep_d;

    // system reset includes power-on reset
    always_ff @(posedge mclk or negedge reset_n or negedge por_n) begin
        if (!reset_n || !por_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    always_ff @(posedge mclk or negedge por_n) begin
        if (!por_n) begin
            por_meta_q <= 1'b0;
            por_sync_q <= 1'b0;
        end else begin
            por_meta_q <= 1'b1;
            por_sync_q <= por_meta_q;
        end
    end

    // next state from one channel field, given the current state
    function automatic seq_state_t decode_field(input seq_state_t cur,
                                                input logic [1:0] fld);
        seq_state_t nxt;
        nxt = cur;
        unique case (cur)
            // [R15] state1 decode
            SEQ_STATE1: begin
                unique case (fld)
                    2'h1: nxt = SEQ_STATE2;
                    2'h2: nxt = SEQ_STATE3;
                    2'h3: nxt = SEQ_FINAL;
                    2'h0: nxt = cur;
                endcase
            end
            // [R16] state2 decode
            SEQ_STATE2: begin
                unique case (fld)
                    2'h1: nxt = SEQ_STATE1;
                    2'h2: nxt = SEQ_STATE3;
                    2'h3: nxt = SEQ_FINAL;
                    2'h0: nxt = cur;
                endcase
            end
            // [R19] state3 decode
            SEQ_STATE3: begin
                unique case (fld)
                    2'h1: nxt = SEQ_STATE1;
                    2'h2: nxt = SEQ_STATE2;
                    2'h3: nxt = SEQ_FINAL;
                    2'h0: nxt = cur;
                endcase
            end
            default: nxt = cur;
        endcase
        return nxt;
    endfunction : decode_field

    // register index from a byte address, taken from address bits 11..2
    function automatic logic [9:0] word_index(input logic [11:0] addr);
        return addr[11:2];
    endfunction : word_index

    logic [3:0] chan_hit;
    logic [7:0] active_select;
    logic [1:0] chan_next_state;
    logic       any_hit;
    logic [9:0] req_index;
    logic       wr_take;
    logic       wr_low;
    logic       cfg_open;
    logic [6:0] count_inc;

    always_comb begin
        // [R18] gate with comparator enables
        chan_hit[2:0] = comparator_match[2:0] & comparator_enable[2:0];
        // [R14] channel 3 source choice
        if (ctl_q.ees == `EES_EXTERNAL) begin
            chan_hit[3] = external_event;
        end else begin
            chan_hit[3] = comparator_match[3] & comparator_enable[3];
        end
        unique case (ctl_q.seq)
            SEQ_STATE1: active_select = ctl_q.sel1;
            SEQ_STATE2: active_select = ctl_q.sel2;
            SEQ_STATE3: active_select = ctl_q.sel3;
            default:    active_select = `RST_SELECT;
        endcase
        // [R17] highest channel has priority
        // [R13] channel n at bits 2n+1..2n
        if (chan_hit[3]) begin
            chan_next_state = active_select[7:6];
        end else if (chan_hit[2]) begin
            chan_next_state = active_select[5:4];
        end else if (chan_hit[1]) begin
            chan_next_state = active_select[3:2];
        end else begin
            chan_next_state = active_select[1:0];
        end
        any_hit = |chan_hit;
    end

    assign req_index = word_index(address);
    // writes land on the edge where waitrequest is low
    assign wr_take   = write && ctl_q.ack;
    assign wr_low    = wr_take && byteenable[0];
    // [R12] configuration only while idle
    assign cfg_open  = !ctl_q.armed && !profiling_active_flag;
    assign count_inc = keep_q.count + 7'h01;

    always_comb begin
        ctl_d  = ctl_q;
        keep_d = keep_q;

        // one wait cycle on every access
        ctl_d.ack = (read || write) && !ctl_q.ack;

        if (read && !ctl_q.ack) begin
            ctl_d.rdata = 32'h0000_0000;
            unique case (req_index)
                `IDX_CONTROL_FIRST: begin
                    ctl_d.rdata[`CTL_ARM_BIT] = ctl_q.armed;
                    ctl_d.rdata[`CTL_EES_LSB +: 2] = ctl_q.ees;
                    ctl_d.rdata[`CTL_ALIGN_LSB +: 2] = ctl_q.align;
                end
                // [R01] count in low seven bits
                // [R08] readable at any time
                `IDX_VALID_LINE_COUNT: ctl_d.rdata[6:0] = keep_q.count;
                `IDX_STATE1_SELECT:    ctl_d.rdata[7:0] = ctl_q.sel1;
                `IDX_STATE2_SELECT:    ctl_d.rdata[7:0] = ctl_q.sel2;
                `IDX_STATE3_SELECT:    ctl_d.rdata[7:0] = ctl_q.sel3;
                `IDX_STATUS: begin
                    ctl_d.rdata[`STS_FULL_BIT] = keep_q.full;
                    ctl_d.rdata[`STS_PROF_BIT] = profiling_active_flag;
                    ctl_d.rdata[`STS_STATE_LSB +: 3] = ctl_q.seq;
                end
                default: ctl_d.rdata = 32'h0000_0000;
            endcase
        end

        // sequencer moves only while armed and not yet final
        if (ctl_q.armed && any_hit && ctl_q.seq != SEQ_FINAL) begin
            ctl_d.seq = decode_field(ctl_q.seq, chan_next_state);
        end

        // [R07] only stored words move the count
        if (ctl_q.armed && trace_word_stored) begin
            if (!keep_q.full || ctl_q.align != `ALIGN_BEGIN) begin
                // [R03] keep counting after wrap
                keep_d.count = count_inc;
                // [R02] wrap sets the full flag
                if (keep_q.count == 7'h7F) begin
                    keep_d.full = 1'b1;
                end
            end
        end

        // [R10] begin alignment stops when buffer fills
        if (ctl_q.armed && keep_q.full && keep_q.count == `RST_COUNT
            && ctl_q.align == `ALIGN_BEGIN) begin
            ctl_d.armed = 1'b0;
            ctl_d.seq   = SEQ_DISARMED;
        end

        if (wr_low) begin
            unique case (req_index)
                `IDX_CONTROL_FIRST: begin
                    ctl_d.ees   = writedata[`CTL_EES_LSB +: 2];
                    ctl_d.align = writedata[`CTL_ALIGN_LSB +: 2];
                    ctl_d.armed = writedata[`CTL_ARM_BIT];
                    if (writedata[`CTL_ARM_BIT]) begin
                        // [R21] arming enters State1
                        ctl_d.seq = SEQ_STATE1;
                        // [R04] arm clears count
                        keep_d.count = `RST_COUNT;
                        // [R20] arm clears full, a wrap wins
                        if (!(keep_d.full && !keep_q.full)) begin
                            keep_d.full = 1'b0;
                        end
                    end else begin
                        ctl_d.seq = SEQ_DISARMED;
                    end
                end
                `IDX_STATE1_SELECT: begin
                    // [R12] guarded write
                    if (cfg_open) begin
                        ctl_d.sel1 = writedata[7:0];
                    end
                end
                `IDX_STATE2_SELECT: begin
                    if (cfg_open) begin
                        ctl_d.sel2 = writedata[7:0];
                    end
                end
                `IDX_STATE3_SELECT: begin
                    if (cfg_open) begin
                        ctl_d.sel3 = writedata[7:0];
                    end
                end
                // [R08] count and status ignore writes
                default: ctl_d.ack = ctl_d.ack;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ctl_q <= '{ack:   1'b0,
                       rdata: 32'h0000_0000,
                       armed: 1'b0,
                       ees:   `RST_CONTROL_EES,
                       align: `RST_CONTROL_ALIGN,
                       sel1:  `RST_SELECT,
                       sel2:  `RST_SELECT,
                       sel3:  `RST_SELECT,
                       seq:   SEQ_DISARMED};
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // [R05] only power-on reset clears these
    // [R06] a system reset leaves the capture count
    always_ff @(posedge mclk or negedge por_sync_q) begin
        if (!por_sync_q) begin
            keep_q <= '{count: `RST_COUNT, full: 1'b0};
        end else begin
            keep_q <= keep_d;
        end
    end

    // [R09] decoding of count with full clear is software's view
    // [R11] full with nonzero count means overwritten data
    assign readdata               = ctl_q.rdata;
    assign waitrequest            = (read || write) && !ctl_q.ack;
    assign session_armed          = ctl_q.armed;
    assign sequencer_state        = ctl_q.seq;
    assign trace_buffer_full_flag = keep_q.full;

endmodule : trace_count_state_sequencer

// [trace_count_state_sequencer_tb.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module trace_count_state_sequencer_tb;
    logic        mclk, reset_n, por_n, read, write, prof, ev, tws, armed;
    logic        waitrequest, full;
    logic [11:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0]  byteenable, match, en;
    logic [2:0]  state;
    int          n_mismatch, n_tests;
    localparam logic [2:0] EXP [0:8] = '{3'h2, 3'h3, 3'h4, 3'h1, 3'h3,
                                         3'h4, 3'h1, 3'h2, 3'h4};

    always #20 mclk = ~mclk;

    trace_count_state_sequencer uut (.mclk(mclk), .reset_n(reset_n),
        .por_n(por_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .trace_word_stored(tws), .comparator_match(match),
        .comparator_enable(en), .external_event(ev),
        .profiling_active_flag(prof), .session_armed(armed),
        .sequencer_state(state), .trace_buffer_full_flag(full));
    trace_partner far (.mclk(mclk), .trace_word_stored(tws),
        .comparator_match(match), .comparator_enable(en),
        .external_event(ev));

    task automatic bus(input logic wr, input logic [9:0] idx,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk);
        address   <= {idx, 2'b00};
        read      <= ~wr;
        write     <= wr;
        writedata <= {24'h0, d};
        // only the watchdog ends a wait for the slave
        do begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        `CHK(q, e)
    endtask : rd

    task automatic t_power_on;
        rd(10'h106, 8'h00);
        rd(10'h107, 8'h00);
        rd(10'h1FF, 8'h00);
    endtask : t_power_on

    task automatic t_count;
        wr(10'h100, 8'h80);
        far.store(3);
        rd(10'h106, 8'h03);
        wr(10'h106, 8'h55);
        rd(10'h106, 8'h03);
        rd(10'h106, 8'h03);
        far.store(125);
        rd(10'h106, 8'h00);
        `CHK(full, 1'b1)
        rd(10'h10B, 8'h81);
        far.store(2);
        rd(10'h106, 8'h02);
        // system reset mid-session keeps the trace bookkeeping
        @(posedge mclk) reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(10'h106, 8'h02);
        `CHK(full, 1'b1)
        wr(10'h100, 8'h80);
        rd(10'h106, 8'h00);
        `CHK(full, 1'b0)
    endtask : t_count

    task automatic t_begin;
        wr(10'h100, 8'h81);
        far.store(128);
        repeat (3) @(posedge mclk);
        `CHK(armed, 1'b0)
        `CHK(state, 3'h0)
        rd(10'h106, 8'h00);
    endtask : t_begin

    task automatic t_decode;
        for (int s = 1; s <= 3; s++) begin
            for (int c = 1; c <= 3; c++) begin
                wr(10'h100, 8'h00);
                wr(10'h107, s == 1 ? 8'(c) : 8'(s * 64 - 64));
                wr(10'h108, 8'(c));
                wr(10'h109, 8'(c));
                wr(10'h100, 8'h80);
                if (s > 1) far.hit(4'h8, 4'hF, 1'b0);
                far.hit(4'h1, 4'hF, 1'b0);
                @(negedge mclk);
                `CHK(state, EXP[s * 3 + c - 4])
            end
        end
    endtask : t_decode

    task automatic t_match;
        wr(10'h100, 8'h00);
        @(posedge mclk) prof <= 1'b1;
        rd(10'h10B, 8'h10);
        wr(10'h107, 8'hC3);
        rd(10'h107, 8'h80);
        @(posedge mclk) prof <= 1'b0;
        wr(10'h107, 8'h43);
        rd(10'h107, 8'h43);
        wr(10'h100, 8'h80);
        wr(10'h107, 8'h00);
        rd(10'h107, 8'h43);
        far.hit(4'h9, 4'h1, 1'b0);
        @(negedge mclk);
        `CHK(state, 3'h4)
        wr(10'h100, 8'h80);
        far.hit(4'h9, 4'hF, 1'b0);
        @(negedge mclk);
        `CHK(state, 3'h2)
        wr(10'h100, 8'h00);
        wr(10'h107, 8'hC0);
        wr(10'h100, 8'h90);
        rd(10'h100, 8'h90);
        far.hit(4'h8, 4'hF, 1'b0);
        @(negedge mclk);
        `CHK(state, 3'h1)
        far.hit(4'h0, 4'hF, 1'b1);
        @(negedge mclk);
        `CHK(state, 3'h4)
        far.hit(4'hF, 4'hF, 1'b1);
        @(negedge mclk);
        `CHK(state, 3'h4)
    endtask : t_match

    task automatic end_sim;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    initial begin
        #400000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        {mclk, reset_n, por_n, read, write, prof} = 6'h0;
        address    = 12'h000;
        writedata  = 32'h0;
        byteenable = 4'hF;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        por_n   <= 1'b1;
        repeat (3) @(posedge mclk);
        t_power_on();
        t_count();
        t_begin();
        t_decode();
        t_match();
        end_sim();
    end
endmodule : trace_count_state_sequencer_tb

// [trace_partner.sv]
`timescale 1ns/100ps

module trace_partner (
    // clock
    input  wire logic mclk,
    // toward the block
    output logic       trace_word_stored,
    output logic [3:0] comparator_match,
    output logic [3:0] comparator_enable,
    output logic       external_event
);
    initial begin
        trace_word_stored = 1'b0;
        comparator_match  = 4'h0;
        comparator_enable = 4'hF;
        external_event    = 1'b0;
    end

    // enables take the given value and keep it after the pulse
    task automatic hit(input logic [3:0] m, input logic [3:0] en,
                       input logic ev);
        @(posedge mclk);
        comparator_match  <= m;
        comparator_enable <= en;
        external_event    <= ev;
        @(posedge mclk);
        comparator_match  <= 4'h0;
        external_event    <= 1'b0;
    endtask : hit

    // one word per cycle, back to back
    task automatic store(input int n);
        @(posedge mclk);
        trace_word_stored <= 1'b1;
        repeat (n) @(posedge mclk);
        trace_word_stored <= 1'b0;
    endtask : store
endmodule : trace_partner

// [trace_seq_cfg.svh]
`ifndef TRACE_SEQ_CFG_SVH
`define TRACE_SEQ_CFG_SVH

// register indices; byte address is four times the index
`define IDX_CONTROL_FIRST      10'h100
`define IDX_VALID_LINE_COUNT   10'h106
`define IDX_STATE1_SELECT      10'h107
`define IDX_STATE2_SELECT      10'h108
`define IDX_STATE3_SELECT      10'h109
`define IDX_STATUS             10'h10B

// debug_control_first fields
`define CTL_ARM_BIT            7
`define CTL_EES_LSB            3
`define CTL_ALIGN_LSB          0

// debug_status_register fields
`define STS_FULL_BIT           7
`define STS_PROF_BIT           4
`define STS_STATE_LSB          0

// field encodings
`define EES_EXTERNAL           2'h2
`define ALIGN_END              2'h0
`define ALIGN_BEGIN            2'h1
`define ALIGN_MID              2'h2
`define NEXT_NONE              2'h0

// reset values
`define RST_SELECT             8'h00
`define RST_CONTROL_EES        2'h0
`define RST_CONTROL_ALIGN      2'h0
`define RST_COUNT              7'h00

`endif

// [trace_seq_chk.sv]
`timescale 1ns/100ps
`include "trace_seq_cfg.svh"

module trace_seq_chk (
    // clock and resets
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        por_n,
    // register bus
    input wire logic [11:0] address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // trace and sequencer
    input wire logic        trace_word_stored,
    input wire logic [3:0]  comparator_match,
    input wire logic [3:0]  comparator_enable,
    input wire logic        external_event,
    input wire logic        session_armed,
    input wire logic [2:0]  sequencer_state,
    input wire logic        trace_buffer_full_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n || !por_n);

    sequence s_arm_taken;
        write && !waitrequest && byteenable[0] && writedata[7] &&
        address[11:2] == `IDX_CONTROL_FIRST && !trace_word_stored;
    endsequence
    sequence s_idle2;
        !session_armed ##1 !session_armed;
    endsequence

    property p_wait_one;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    property p_rd_width;
        read && !waitrequest |-> readdata[31:8] == 24'h0;
    endproperty
    property p_arm_write;
        s_arm_taken |=> session_armed && sequencer_state == 3'h1 &&
            !trace_buffer_full_flag;
    endproperty
    property p_arm_rise;
        $rose(session_armed) |-> sequencer_state == 3'h1;
    endproperty
    property p_idle;
        s_idle2 |-> sequencer_state == 3'h0;
    endproperty
    property p_no_match;
        session_armed && !write && !trace_word_stored && !external_event &&
        (comparator_match & comparator_enable) == 4'h0
            // a begin-aligned session ends itself once the buffer fills
            |=> $stable(sequencer_state) || (!session_armed &&
                sequencer_state == 3'h0 && trace_buffer_full_flag);
    endproperty
    property p_final;
        sequencer_state == 3'h4 && !write
            |=> sequencer_state inside {3'h4, 3'h0};
    endproperty
    // system reset must not clear the flag, so only power-on disables
    property p_full_keep;
        disable iff (!por_n)
        trace_buffer_full_flag && !write |=> trace_buffer_full_flag;
    endproperty

    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest not low one cycle after request");
    a_rd_width: assert property (p_rd_width)
        else $error("read data above low byte not zero");
    a_arm_write: assert property (p_arm_write)
        else $error("arm write did not restart the session");
    a_arm_rise: assert property (p_arm_rise)
        else $error("arming did not enter the first state");
    a_idle: assert property (p_idle)
        else $error("sequencer not idle while disarmed");
    a_no_match: assert property (p_no_match)
        else $error("sequencer moved without an enabled match");
    a_final: assert property (p_final)
        else $error("sequencer left the final state");
    a_full_keep: assert property (p_full_keep)
        else $error("full flag lost without arm write");
endmodule : trace_seq_chk

bind trace_count_state_sequencer trace_seq_chk chk (
    .mclk(mclk), .reset_n(reset_n), .por_n(por_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .trace_word_stored(trace_word_stored),
    .comparator_match(comparator_match),
    .comparator_enable(comparator_enable),
    .external_event(external_event), .session_armed(session_armed),
    .sequencer_state(sequencer_state),
    .trace_buffer_full_flag(trace_buffer_full_flag));

// [trace_seq_pkg.sv]
package trace_seq_pkg;

    typedef enum logic [2:0] {
        SEQ_DISARMED = 3'b000,
        SEQ_STATE1   = 3'b001,
        SEQ_STATE2   = 3'b010,
        SEQ_STATE3   = 3'b011,
        SEQ_FINAL    = 3'b100
    } seq_state_t;

    // state cleared by any reset
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        armed;
        logic [1:0]  ees;
        logic [1:0]  align;
        logic [7:0]  sel1;
        logic [7:0]  sel2;
        logic [7:0]  sel3;
        seq_state_t  seq;
    } ctl_regs_t;

    // state cleared only by power-on reset
    typedef struct packed {
        logic [6:0]  count;
        logic        full;
    } keep_regs_t;

endpackage : trace_seq_pkg
